/* File: inc/smi_defines.svh */
// Purpose: offsets, field positions and reset values of the smi aggregator
// Assumes: byte-wide registers, one per aligned apb word
// Notes:   offsets are register indexes; byte address is four times the index
// Operation
// - enable register a gates parallel port (1), uart b (2), uart a (3), floppy (4), watchdog (7); 0,5,6 reserved.
// - enable register b gates mouse (0), keyboard (1), infrared activity (2); bits 3 and 5 reserved.
// - enable b bit 4 routes the keyboard controller port line into the group path, 0 blocks it.
// - enable b bit 6 carries the group interrupt in the serial irq stream.
// - enable b bit 7 drives the group interrupt onto the shared pin when the group is selected; 0 then lets the pin float.
// - status register a mirrors sources a at enable-a positions and clears only at the source.
// - status b bits 0 and 1 mirror mouse and keyboard requests and clear at the source.
// - status b bit 2 sets on any edge of the selected infrared receive input, after the mux.
// - status b bit 2 clears on a read of status register b, unless an infrared edge arrives in the same cycle.
// - status b bit 4 mirrors the keyboard controller port line and clears at the source.
// - the shared pin select bit chooses between the irq10 interrupt and the group interrupt.
`ifndef SMI_DEFINES_SVH
`define SMI_DEFINES_SVH
`define SMI_IDX_ENABLE_A    8'hb4
`define SMI_IDX_ENABLE_B    8'hb5
`define SMI_IDX_STATUS_A    8'hb6
`define SMI_IDX_STATUS_B    8'hb7
`define SMI_IDX_RSVD        8'hb8
`define SMI_IDX_PIN_CTRL    8'hb9
`define SMI_IDX_IRQ_STATUS  8'hba
`define SMI_IDX_IRQ_MASK    8'hbb
`define SMI_MASK_A          8'h9e
`define SMI_MASK_B_EN       8'hd7
`define SMI_MASK_B_SRC      8'h17
`define SMI_BIT_KBC_LINE    4
`define SMI_BIT_IR          2
`define SMI_BIT_SERIRQ      6
`define SMI_BIT_PIN         7
`define SMI_BIT_PIN_SEL     7
`define SMI_BIT_IR_SEL      0
`define SMI_RESET_BYTE      8'h00
`define SMI_EVT_GROUP       0
`define SMI_EVT_IR          1
`define SMI_EVT_W           2
`endif

/* File: inc/smi_pkg.sv */
// Purpose: types shared by the smi aggregator modules
// Assumes: nothing
// Notes:   constants live in smi_defines.svh
package smi_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_ACCESS = 2'b01
  } apb_state_e;
endpackage

/* File: inc/smi_src_if.sv */
// Purpose: carries synchronised source levels between the sync stage and the top
// Assumes: single clock
// Notes:   none
interface smi_src_if;
  logic [7:0] src_a;
  logic [7:0] src_b;
  logic       ir_edge;
  modport producer (output src_a, output src_b, output ir_edge);
  modport consumer (input src_a, input src_b, input ir_edge);
endinterface

/* File: verilog/smi_src_sync.sv */
// Purpose: two-stage synchronisers for source levels and infrared edge detect
// Assumes: sources are asynchronous to CLK
// Notes:   first stage is read by the second stage only
`include "smi_defines.svh"
module smi_src_sync (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] raw_a,
  input  wire logic [7:0] raw_b,
  input  wire logic       ir_raw,
  smi_src_if.producer     src
);
  logic [7:0] a_meta_reg;
  logic [7:0] a_sync_reg;
  logic [7:0] b_meta_reg;
  logic [7:0] b_sync_reg;
  logic [2:0] ir_reg;

  ////////////////////////////////////////////////////////////////////////
  // double flop of source levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_meta_reg <= `SMI_RESET_BYTE;
      a_sync_reg <= `SMI_RESET_BYTE;
      b_meta_reg <= `SMI_RESET_BYTE;
      b_sync_reg <= `SMI_RESET_BYTE;
    end else begin
      a_meta_reg <= raw_a;
      a_sync_reg <= a_meta_reg;
      b_meta_reg <= raw_b;
      b_sync_reg <= b_meta_reg;
    end
  end

  // infrared line: two sync flops plus one history flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_reg <= 3'h0;
    end else begin
      ir_reg <= {ir_reg[1:0], ir_raw};
    end
  end

  assign src.src_a   = a_sync_reg;
  assign src.src_b   = b_sync_reg;
  assign src.ir_edge = ir_reg[2] ^ ir_reg[1];
endmodule

/* File: verilog/smi_apb_slave.sv */
// Purpose: apb slave phase tracking and address decode
// Assumes: 32-bit apb, word-aligned registers
// Notes:   answers in the first access cycle, pslverr on unmapped words
`include "smi_defines.svh"
module smi_apb_slave (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       idx,
  output logic             hit,
  output logic             in_access
);
  smi_pkg::apb_state_e state_reg;

  ////////////////////////////////////////////////////////////////////////
  // phase tracking, one access per setup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= smi_pkg::APB_IDLE;
    end else begin
      case (state_reg)
        smi_pkg::APB_IDLE:   state_reg <= (psel && !penable) ? smi_pkg::APB_ACCESS : smi_pkg::APB_IDLE;
        smi_pkg::APB_ACCESS: state_reg <= smi_pkg::APB_IDLE;
        default:             state_reg <= smi_pkg::APB_IDLE;
      endcase
    end
  end

  // decode
  assign in_access = (state_reg == smi_pkg::APB_ACCESS) && psel && penable;
  assign idx       = paddr[9:2];
  assign hit       = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                     (idx >= `SMI_IDX_ENABLE_A) && (idx <= `SMI_IDX_IRQ_MASK);
  assign wr_stb    = in_access && pwrite && hit;
  assign rd_stb    = in_access && !pwrite && hit;
endmodule

/* File: verilog/smi_aggregator.sv */
// Purpose: gathers peripheral interrupt levels into the group system management interrupt
// Assumes: CLK 25 MHz, sources asynchronous, apb register access
// Notes:   group interrupt also raises a sticky event bit for the local interrupt output
//
// Chosen here: the APB interface to the registers.
`include "smi_defines.svh"
module smi_aggregator (
  input  logic        CLK,
  input  logic        RST_B,
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [11:0] PADDR,
  input  logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  input  logic [7:0]  SRC_A,
  input  logic        MOUSE_REQ,
  input  logic        KEYBOARD_REQ,
  input  logic        KBC_PORT_LINE,
  input  logic        UART_B_RECEIVE_INPUT,
  input  logic        INFRARED_RECEIVE_INPUT,
  input  logic        IRQ10_REQ,
  output logic        SYS_MGMT_IRQ_N_O,
  output logic        SYS_MGMT_IRQ_N_OE,
  output logic        SERIRQ_GROUP_REQ,
  output logic        IRQ_OUT
);
  smi_src_if src ();

  smi_pkg::byte_t enable_a_reg;
  smi_pkg::byte_t enable_b_reg;
  smi_pkg::byte_t status_b_ir_reg;
  smi_pkg::byte_t pin_ctrl_reg;
  smi_pkg::byte_t irq_status_reg;
  smi_pkg::byte_t irq_mask_reg;
  logic           wr_stb;
  logic           rd_stb;
  logic [7:0]     idx;
  logic           hit;
  logic           in_access;
  logic           ir_sel;
  logic           ir_muxed;
  logic [7:0]     raw_b;
  smi_pkg::byte_t status_a;
  smi_pkg::byte_t status_b;
  logic           group_next;
  logic           group_reg;
  logic           group_prev_reg;
  smi_pkg::byte_t rd_next;
  smi_pkg::byte_t irq_status_next;

  // masks a byte to its defined bits
  function automatic smi_pkg::byte_t keep(input smi_pkg::byte_t v, input smi_pkg::byte_t m);
    keep = v & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // infrared receive selection ahead of the synchroniser
  assign ir_sel   = pin_ctrl_reg[`SMI_BIT_IR_SEL];
  assign ir_muxed = ir_sel ? INFRARED_RECEIVE_INPUT : UART_B_RECEIVE_INPUT;
  assign raw_b    = {3'h0, KBC_PORT_LINE, 2'h0, KEYBOARD_REQ, MOUSE_REQ};

  smi_src_sync u_sync (
    .clk    (CLK),
    .rst_b  (RST_B),
    .raw_a  (SRC_A),
    .raw_b  (raw_b),
    .ir_raw (ir_muxed),
    .src    (src.producer)
  );

  smi_apb_slave u_apb (
    .clk       (CLK),
    .rst_b     (RST_B),
    .psel      (PSEL),
    .penable   (PENABLE),
    .pwrite    (PWRITE),
    .paddr     (PADDR),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb),
    .idx       (idx),
    .hit       (hit),
    .in_access (in_access)
  );

  ////////////////////////////////////////////////////////////////////////
  // live status views, following their sources
  assign status_a = keep(src.src_a, `SMI_MASK_A);
  assign status_b = keep(src.src_b, `SMI_MASK_B_SRC) | status_b_ir_reg;

  // enable, pin control and interrupt mask registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      enable_a_reg <= `SMI_RESET_BYTE;
      enable_b_reg <= `SMI_RESET_BYTE;
      pin_ctrl_reg <= `SMI_RESET_BYTE;
      irq_mask_reg <= `SMI_RESET_BYTE;
    end else if (wr_stb) begin
      case (idx)
        `SMI_IDX_ENABLE_A:  enable_a_reg <= keep(PWDATA[7:0], `SMI_MASK_A);
        `SMI_IDX_ENABLE_B:  enable_b_reg <= keep(PWDATA[7:0], `SMI_MASK_B_EN);
        `SMI_IDX_PIN_CTRL:  pin_ctrl_reg <= keep(PWDATA[7:0], 8'h81);
        `SMI_IDX_IRQ_MASK:  irq_mask_reg <= keep(PWDATA[7:0], 8'h03);
        default:            enable_a_reg <= enable_a_reg;
      endcase
    end
  end

  // infrared activity: set on edge, cleared by reading status b, set wins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      status_b_ir_reg <= `SMI_RESET_BYTE;
    end else if (src.ir_edge) begin
      status_b_ir_reg <= 8'h04;
    end else if (rd_stb && idx == `SMI_IDX_STATUS_B) begin
      status_b_ir_reg <= `SMI_RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // group combine: kbc line only when routed
  always_comb begin
    group_next = |(status_a & enable_a_reg);
    group_next = group_next | (|(status_b & enable_b_reg & 8'h07));
    group_next = group_next | (status_b[`SMI_BIT_KBC_LINE] & enable_b_reg[`SMI_BIT_KBC_LINE]);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      group_reg      <= 1'b0;
      group_prev_reg <= 1'b0;
    end else begin
      group_reg      <= group_next;
      group_prev_reg <= group_reg;
    end
  end

  // shared pin: select bit picks irq10 or group, route bit enables drive
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SYS_MGMT_IRQ_N_O  <= 1'b1;
      SYS_MGMT_IRQ_N_OE <= 1'b0;
      SERIRQ_GROUP_REQ  <= 1'b0;
    end else begin
      if (pin_ctrl_reg[`SMI_BIT_PIN_SEL]) begin
        SYS_MGMT_IRQ_N_O  <= ~group_next;
        SYS_MGMT_IRQ_N_OE <= enable_b_reg[`SMI_BIT_PIN];
      end else begin
        SYS_MGMT_IRQ_N_O  <= IRQ10_REQ;
        SYS_MGMT_IRQ_N_OE <= 1'b1;
      end
      SERIRQ_GROUP_REQ <= group_next & enable_b_reg[`SMI_BIT_SERIRQ];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // local sticky events: group rise and infrared edge, write one to clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_stb && idx == `SMI_IDX_IRQ_STATUS) begin
      irq_status_next = irq_status_reg & ~PWDATA[7:0];
    end
    if (group_reg && !group_prev_reg) begin
      irq_status_next[`SMI_EVT_GROUP] = 1'b1;
    end
    if (src.ir_edge) begin
      irq_status_next[`SMI_EVT_IR] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_status_reg <= `SMI_RESET_BYTE;
      IRQ_OUT        <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      IRQ_OUT        <= |(irq_status_next & ~irq_mask_reg); // a set mask bit holds its event back
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    case (idx)
      `SMI_IDX_ENABLE_A:   rd_next = enable_a_reg;
      `SMI_IDX_ENABLE_B:   rd_next = enable_b_reg;
      `SMI_IDX_STATUS_A:   rd_next = status_a;
      `SMI_IDX_STATUS_B:   rd_next = status_b;
      `SMI_IDX_RSVD:       rd_next = `SMI_RESET_BYTE;
      `SMI_IDX_PIN_CTRL:   rd_next = pin_ctrl_reg;
      `SMI_IDX_IRQ_STATUS: rd_next = irq_status_reg;
      `SMI_IDX_IRQ_MASK:   rd_next = irq_mask_reg;
      default:             rd_next = `SMI_RESET_BYTE;
    endcase
  end

  // registered apb answer, one cycle after setup
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      PRDATA  <= {24'h00_0000, (PSEL && !PENABLE && !PWRITE && hit) ? rd_next : `SMI_RESET_BYTE};
    end
  end
endmodule

/* File: verification/smi_aggregator_chk.sv */
// Purpose: port-level checks of the smi aggregator
// Assumes: apb master keeps the setup then access order
// Notes:   routing bits are shadowed from observed writes
module smi_aggregator_chk (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        IRQ10_REQ,
  input wire logic        SYS_MGMT_IRQ_N_O,
  input wire logic        SYS_MGMT_IRQ_N_OE,
  input wire logic        SERIRQ_GROUP_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sel_reg;
  logic [7:0] enb_reg;
  logic       wr;
  logic       map;
  // completed writes and mapped window
  assign wr  = PSEL && PENABLE && PREADY && PWRITE;
  assign map = PADDR[1:0] == 2'h0 && PADDR >= 12'h2d0 && PADDR <= 12'h2ec;
  // shadow of pin select and enable b
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_reg <= 1'b0;
      enb_reg <= 8'h00;
    end else begin
      if (wr && PADDR == 12'h2e4) sel_reg <= PWDATA[7];
      if (wr && PADDR == 12'h2d4) enb_reg <= PWDATA[7:0];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  err_unmapped_a: assert property (PREADY && !map |-> PSLVERR) else $error("unmapped access without error");
  err_only_a: assert property (PSLVERR |-> PREADY && !map) else $error("error on mapped access");
  rsvd_zero_a: assert property (PREADY && !PWRITE && PADDR == 12'h2e0 |-> PRDATA == 32'h0)
    else $error("reserved register not zero");
  serirq_gate_a: assert property ((!enb_reg[6]) [*2] |-> !SERIRQ_GROUP_REQ)
    else $error("serial irq request while disabled");
  pin_float_a: assert property ((sel_reg && !enb_reg[7]) [*2] |-> !SYS_MGMT_IRQ_N_OE)
    else $error("pin driven while disabled");
  pin_irq10_a: assert property ((!sel_reg && $stable(IRQ10_REQ)) [*4] |->
    SYS_MGMT_IRQ_N_OE && SYS_MGMT_IRQ_N_O == IRQ10_REQ) else $error("pin not following irq10");
endmodule
bind smi_aggregator smi_aggregator_chk u_chk (.*);

/* File: verification/smi_host_model.sv */
// Purpose: host power-management side of the shared pin
// Assumes: pull-up on the shared pin
// Notes:   a released pin reads high
module smi_host_model (
  input  wire logic pin_val,
  input  wire logic pin_en,
  input  wire logic serirq_req,
  output wire logic pin_level,
  output wire logic smi_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up wins when nobody drives
  assign pin_level = pin_en ? pin_val : 1'b1;
  assign smi_seen  = !pin_level || serirq_req;
endmodule

/* File: verification/smi_aggregator_tb.sv */
// Purpose: register-level tests of the smi aggregator
// Assumes: zero-wait apb slave, two-edge source sync
// Notes:   byte address is four times the index
`include "smi_defines.svh"
module smi_aggregator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, psel, pen, pwr, mreq, kreq, kbc, urx, irx, irq10, er;
  logic        prdy, perr, pin_o, pin_oe, ser, irq, lvl, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  srca, e;
  int          fail_count, n_checks;
  int          bsel[3] = '{0, 1, 4};
  smi_aggregator u_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr), .SRC_A(srca), .MOUSE_REQ(mreq),
    .KEYBOARD_REQ(kreq), .KBC_PORT_LINE(kbc), .UART_B_RECEIVE_INPUT(urx), .INFRARED_RECEIVE_INPUT(irx),
    .IRQ10_REQ(irq10), .SYS_MGMT_IRQ_N_O(pin_o), .SYS_MGMT_IRQ_N_OE(pin_oe), .SERIRQ_GROUP_REQ(ser),
    .IRQ_OUT(irq));
  smi_host_model u_host (.pin_val(pin_o), .pin_en(pin_oe), .serirq_req(ser), .pin_level(lvl), .smi_seen(seen));
  ////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      fail_count++;
      $display("ERROR %s exp %h seen %h", nm, x, s);
    end
  endtask
  // one apb transfer, request held until ready is sampled
  task automatic apb(input logic dir, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, dir, a, d};
    @(posedge clk);
    pen <= 1'b1;
    // ready, read data and error are taken at the rising edge that shows ready
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rd = prdata;
    er = perr;
    {psel, pen} <= 2'b00;
    if (prdy !== 1'b1) fail_count++;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, x);
  endtask
  task automatic w(input int c);
    repeat (c) @(posedge clk);
  endtask
  // group flags seen at the host, sampled off the edge
  task automatic flags(input logic es, input logic el);
    @(negedge clk);
    chk("serirq", {31'h0, ser}, {31'h0, es});
    chk("pin", {31'h0, lvl}, {31'h0, el});
    @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    #400000;
    fail_count++;
    close_out();
  end
  // main sequence
  initial begin
    {psel, pen, pwr, mreq, kreq, kbc, urx, irx, er, rst_b} = '0;
    {irq10, paddr, pwdata, srca, e} = {1'b1, 12'h0, 32'h0, 8'h0, 8'h0};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) rc("reset value", 12'h2d0 + 12'(4 * i), 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    flags(1'b0, 1'b1);
    $display("test reset done");
    apb(1'b1, 12'h2d0, 32'hff);
    rc("enable a", 12'h2d0, {24'h0, `SMI_MASK_A});
    apb(1'b1, 12'h2d4, 32'hff);
    rc("enable b", 12'h2d4, {24'h0, `SMI_MASK_B_EN});
    apb(1'b1, 12'h2e4, 32'h81);
    for (int i = 0; i < 8; i++) begin
      srca <= 8'h1 << i;
      e = 8'h1 << i & `SMI_MASK_A;
      w(6);
      flags(e != 8'h0, e == 8'h0);
      rc("status a", 12'h2d8, {24'h0, e});
    end
    apb(1'b1, 12'h2d0, 32'h0);
    srca <= 8'h9e;
    w(6);
    flags(1'b0, 1'b1);
    rc("status a gated", 12'h2d8, 32'h9e);
    srca <= 8'h0;
    w(6);
    rc("status a clear", 12'h2d8, 32'h0);
    $display("test sources a done");
    for (int j = 0; j < 3; j++) begin
      e = 8'h1 << bsel[j];
      {kbc, kreq, mreq} <= {e[4], e[1], e[0]};
      apb(1'b1, 12'h2d4, 32'hc0);
      w(6);
      flags(1'b0, 1'b1);
      rc("status b", 12'h2dc, {24'h0, e});
      apb(1'b1, 12'h2d4, {24'h0, 8'hc0 | e});
      w(3);
      flags(1'b1, 1'b0);
      {kbc, kreq, mreq} <= 3'b000;
      w(6);
      flags(1'b0, 1'b1);
    end
    $display("test sources b done");
    apb(1'b1, 12'h2d4, 32'hc4);
    urx <= 1'b1;
    w(6);
    rc("ir unselected", 12'h2dc, 32'h0);
    irx <= 1'b1;
    w(6);
    flags(1'b1, 1'b0);
    rc("ir edge", 12'h2dc, 32'h4);
    w(2);
    flags(1'b0, 1'b1);
    rc("ir read clear", 12'h2dc, 32'h0);
    apb(1'b1, 12'h2e4, 32'h80);
    urx <= 1'b0;
    w(6);
    rc("ir uart input", 12'h2dc, 32'h4);
    $display("test infrared done");
    mreq <= 1'b1;
    apb(1'b1, 12'h2d4, 32'h41);
    w(3);
    flags(1'b1, 1'b1);
    @(negedge clk);
    chk("pin released", {31'h0, pin_oe}, 32'h0);
    @(posedge clk);
    mreq <= 1'b0;
    apb(1'b1, 12'h2e4, 32'h0);
    irq10 <= 1'b0;
    w(6);
    flags(1'b0, 1'b0);
    $display("test pin routing done");
    apb(1'b1, 12'h2e8, 32'h3);
    apb(1'b1, 12'h2ec, 32'h3);
    apb(1'b1, 12'h2e4, 32'h80);
    apb(1'b1, 12'h2d4, 32'hc1);
    mreq <= 1'b1;
    w(6);
    @(negedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rc("event status", 12'h2e8, 32'h1);
    apb(1'b1, 12'h2ec, 32'h0);
    w(2);
    @(negedge clk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h2e8, 32'h1);
    w(2);
    @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    @(posedge clk);
    mreq <= 1'b0;
    $display("test interrupt done");
    close_out();
  end
endmodule
